/* File: srcf_pkg.sv */
`default_nettype none
package srcf_pkg;
    // clock and timing
    localparam int unsigned CLK_NS    = 20;     // 50 MHz
    localparam int unsigned CLK_KHZ   = 1000000 / CLK_NS;
    localparam int unsigned LONG_MS   = 1000;   // long key press
    localparam int unsigned DONE_MS   = 1000;   // completion blink
    localparam int unsigned FTICK_NS  = 10000;  // filter step, 0.01 ms
    localparam int unsigned FTICK_CYC = FTICK_NS / CLK_NS;
    // setting limits and reset values
    localparam logic [15:0] RAMP_MAX   = 16'h2710; // 10000 ms
    localparam logic [15:0] RAMP_RST   = 16'h0000;
    localparam logic [15:0] FILT_RST   = 16'h0028; // 0.40 ms
    localparam logic [15:0] FULL_SPEED = 16'h7fff; // code of max speed
    localparam logic [15:0] OFS_LIM    = 16'h03e8; // offset magnitude cap
    // register byte addresses
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_ACC  = 5'h04;
    localparam logic [4:0] A_DEC  = 5'h08;
    localparam logic [4:0] A_FILT = 5'h0c;
    localparam logic [4:0] A_OFS  = 5'h10;
    localparam logic [4:0] A_STAT = 5'h14;
    localparam logic [4:0] A_SPD  = 5'h18;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam int unsigned FRAC = 16;

    typedef enum logic [1:0] {
        UI_UTIL  = 2'b00,
        UI_ENTRY = 2'b01,
        UI_SHOW  = 2'b10,
        UI_DONE  = 2'b11
    } srcf_ui_t;

    typedef struct packed {
        logic enter;
        logic shift;
        logic mode;
        logic left;
        logic right;
        logic up;
        logic down;
    } srcf_keys_t;

    typedef struct packed {
        srcf_ui_t    screen;
        logic        blink;
        logic [15:0] value;
    } srcf_disp_t;

    // merge a write word into a register under byte strobes
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    // clamp a 17-bit signed value into 16 bits
    function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
        if (v > 17'sh07fff) return 16'sh7fff;
        if (v < -17'sh08000) return -16'sh8000;
        return v[15:0];
    endfunction
endpackage
`default_nettype wire

/* File: srcf_div.sv */
`timescale 1ns/1ps
`default_nettype none
module srcf_div (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        start,
    input  wire logic [31:0] num,
    input  wire logic [15:0] den,
    output logic             done_q,
    output logic [31:0]      quo_q
);
    logic [16:0] rem_q;
    logic [5:0]  cnt_q;
    logic        busy_q;
    logic [16:0] trial;
    logic        fits;

    // one restoring step per clock, 32 clocks a quotient
    assign trial = {rem_q[15:0], quo_q[31]};
    assign fits  = trial >= {1'b0, den};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rem_q  <= 17'h00000;
            quo_q  <= 32'h00000000;
            cnt_q  <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= busy_q && cnt_q == 6'h1f;
            if (start && !busy_q) begin
                rem_q  <= 17'h00000;
                quo_q  <= num;
                cnt_q  <= 6'h00;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q  <= fits ? trial - {1'b0, den} : trial;
                quo_q  <= {quo_q[30:0], fits};
                cnt_q  <= cnt_q + 6'h01;
                busy_q <= cnt_q != 6'h1f;
            end
        end
    end
endmodule // srcf_div
`default_nettype wire

/* File: srcf_top.sv */
// Functional notes
// - manual offset acts like automatic one
// - enter, or long shift, opens adjustment
// - left/right or short shift shows offset
// - up/down keys step displayed offset
// - left/right or short mode commits, blinks
// - enter or long shift returns to selection
// - steps become constant-slope ramps
// - accel time 0..10000 ms, reset 0
// - decel time 0..10000 ms, reset 0
// - both times zero bypasses ramp
// - accel time spans standstill to max
// - first-order lag filter on reference
// - filter constant 0.01 ms units, default 40
// - committed offset stays stored and applied
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module srcf_top #(
    parameter int unsigned LONG_CYC = srcf_pkg::LONG_MS * srcf_pkg::CLK_KHZ,
    parameter int unsigned DONE_CYC = srcf_pkg::DONE_MS * srcf_pkg::CLK_KHZ,
    parameter int unsigned CYC_MS   = srcf_pkg::CLK_KHZ
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [4:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [4:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire srcf_pkg::srcf_keys_t keys,
    input  wire logic               servo_on_n,
    input  wire logic signed [15:0] vref_code,
    output logic signed [15:0]      speed_cmd_q,
    output srcf_pkg::srcf_disp_t    disp_q
);
    import srcf_pkg::*;

    // register file
    logic        util_sel_q;
    logic [15:0] acc_q, dec_q, filt_q;
    logic signed [15:0] offset_q, edit_q;
    // axi state
    logic [4:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_have_q, w_have_q;
    // keypad and screen
    srcf_keys_t  keys_q;
    srcf_ui_t    ui_q;
    logic [31:0] shift_cnt_q, mode_cnt_q, done_cnt_q;
    // datapath
    logic signed [15:0] sref_q, ramp_q;
    logic [31:0] racc_q;
    logic signed [31:0] y_q;
    logic [15:0] ftick_q;
    logic        neg_q;

    // write channel handshakes; address and data taken in either order
    logic aw_hs, w_hs, do_wr, aw_have_n, w_have_n, bvalid_n;
    assign aw_hs     = s_axi_awvalid && s_axi_awready;
    assign w_hs      = s_axi_wvalid && s_axi_wready;
    assign do_wr     = aw_have_q && w_have_q && !s_axi_bvalid;
    assign aw_have_n = (aw_have_q || aw_hs) && !do_wr;
    assign w_have_n  = (w_have_q || w_hs) && !do_wr;
    assign bvalid_n  = do_wr || (s_axi_bvalid && !s_axi_bready);

    // write decode
    logic [31:0] wr_word_acc, wr_word_dec, wr_word_flt, wr_word_ctl;
    logic [15:0] acc_wr, dec_wr;
    logic        wr_ctl, wr_acc, wr_dec, wr_flt, wr_hit;
    assign wr_ctl = do_wr && awaddr_q == A_CTRL;
    assign wr_acc = do_wr && awaddr_q == A_ACC;
    assign wr_dec = do_wr && awaddr_q == A_DEC;
    assign wr_flt = do_wr && awaddr_q == A_FILT;
    assign wr_hit = wr_ctl || wr_acc || wr_dec || wr_flt;
    assign wr_word_ctl = strb_merge({31'h0, util_sel_q}, wdata_q, wstrb_q);
    assign wr_word_acc = strb_merge({16'h0, acc_q}, wdata_q, wstrb_q);
    assign wr_word_dec = strb_merge({16'h0, dec_q}, wdata_q, wstrb_q);
    assign wr_word_flt = strb_merge({16'h0, filt_q}, wdata_q, wstrb_q);
    // settings above the top of range are held at the top
    assign acc_wr = wr_word_acc[31:0] > {16'h0, RAMP_MAX} ? RAMP_MAX
                    : wr_word_acc[15:0];
    assign dec_wr = wr_word_dec[31:0] > {16'h0, RAMP_MAX} ? RAMP_MAX
                    : wr_word_dec[15:0];

    // read decode; unmapped addresses answer with an error
    logic        ar_hs, rd_hit;
    logic [31:0] rd_word;
    assign ar_hs  = s_axi_arvalid && s_axi_arready;
    assign rd_hit = s_axi_araddr == A_CTRL || s_axi_araddr == A_ACC ||
                    s_axi_araddr == A_DEC || s_axi_araddr == A_FILT ||
                    s_axi_araddr == A_OFS || s_axi_araddr == A_STAT ||
                    s_axi_araddr == A_SPD;
    assign rd_word =
        s_axi_araddr == A_CTRL ? {31'h0, util_sel_q} :
        s_axi_araddr == A_ACC  ? {16'h0, acc_q} :
        s_axi_araddr == A_DEC  ? {16'h0, dec_q} :
        s_axi_araddr == A_FILT ? {16'h0, filt_q} :
        s_axi_araddr == A_OFS  ? {{16{offset_q[15]}}, offset_q} :
        s_axi_araddr == A_STAT ? {{16{ramp_q[15]}}, ramp_q[15:2],
                                  ui_q} :
        s_axi_araddr == A_SPD  ? {{16{speed_cmd_q[15]}}, speed_cmd_q} :
        32'h00000000;

    // write side of the slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 5'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
        end else begin
            if (aw_hs) awaddr_q <= s_axi_awaddr;
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) s_axi_bresp <= wr_hit ? RESP_OK : RESP_ERR;
            aw_have_q     <= aw_have_n;
            w_have_q      <= w_have_n;
            s_axi_bvalid  <= bvalid_n;
            s_axi_awready <= !aw_have_n && !bvalid_n;
            s_axi_wready  <= !w_have_n && !bvalid_n;
        end
    end

    // read side of the slave: one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OK;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OK : RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // settings take effect on the cycle after the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            util_sel_q <= 1'b0;
            acc_q      <= RAMP_RST;
            dec_q      <= RAMP_RST;
            filt_q     <= FILT_RST;
        end else begin
            if (wr_ctl) util_sel_q <= wr_word_ctl[0];
            if (wr_acc) acc_q <= acc_wr;
            if (wr_dec) dec_q <= dec_wr;
            if (wr_flt) filt_q <= wr_word_flt[15:0];
        end
    end

    // key edges and press lengths; a long press fires once while held
    logic p_enter, p_left, p_right, p_up, p_down, lr;
    logic shift_long, shift_short, mode_short;
    assign p_enter = keys.enter && !keys_q.enter;
    assign p_left  = keys.left && !keys_q.left;
    assign p_right = keys.right && !keys_q.right;
    assign p_up    = keys.up && !keys_q.up;
    assign p_down  = keys.down && !keys_q.down;
    assign lr      = p_left || p_right;
    assign shift_long  = keys.shift && shift_cnt_q == LONG_CYC - 1;
    assign shift_short = !keys.shift && keys_q.shift &&
                         shift_cnt_q < LONG_CYC;
    assign mode_short  = !keys.mode && keys_q.mode &&
                         mode_cnt_q < LONG_CYC;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keys_q      <= '0;
            shift_cnt_q <= 32'h00000000;
            mode_cnt_q  <= 32'h00000000;
        end else begin
            keys_q <= keys;
            if (!keys.shift) shift_cnt_q <= 32'h00000000;
            else if (shift_cnt_q < LONG_CYC) shift_cnt_q <= shift_cnt_q + 1;
            if (!keys.mode) mode_cnt_q <= 32'h00000000;
            else if (mode_cnt_q < LONG_CYC) mode_cnt_q <= mode_cnt_q + 1;
        end
    end

    // offset editing; steps stop at the cap rather than wrap
    logic ed_ok, ed_up, ed_dn, leave;
    assign ed_ok = !servo_on_n;
    assign ed_up = ed_ok && p_up && edit_q < $signed(OFS_LIM);
    assign ed_dn = ed_ok && p_down && edit_q > -$signed(OFS_LIM);
    assign leave = p_enter || shift_long;

    // operator screen sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ui_q       <= UI_UTIL;
            edit_q     <= 16'sh0000;
            offset_q   <= 16'sh0000;
            done_cnt_q <= 32'h00000000;
        end else begin
            case (ui_q)
                UI_UTIL: begin
                    if (util_sel_q && leave) ui_q <= UI_ENTRY;
                end
                UI_ENTRY: begin
                    if (leave) ui_q <= UI_UTIL;
                    else if (lr || shift_short) begin
                        ui_q   <= UI_SHOW;
                        edit_q <= offset_q;
                    end
                end
                UI_SHOW: begin
                    if (leave) ui_q <= UI_UTIL;
                    else if (lr || mode_short) begin
                        offset_q   <= edit_q;
                        done_cnt_q <= 32'h00000000;
                        ui_q       <= UI_DONE;
                    end else if (ed_up) edit_q <= edit_q + 16'sh0001;
                    else if (ed_dn) edit_q <= edit_q - 16'sh0001;
                end
                UI_DONE: begin
                    done_cnt_q <= done_cnt_q + 1;
                    if (done_cnt_q == DONE_CYC - 1) ui_q <= UI_ENTRY;
                end
                default: ui_q <= UI_UTIL;
            endcase
        end
    end

    // screen outputs; same path as the auto utility, value typed in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disp_q <= '0;
        end else begin
            disp_q.screen <= ui_q;
            disp_q.blink  <= ui_q == UI_DONE;
            disp_q.value  <= ui_q == UI_SHOW ? edit_q : offset_q;
        end
    end

    // ramp toward the offset-corrected reference
    logic gt, lt, mag_up, ramp_bypass;
    logic [15:0] t_ms;
    logic [31:0] period, racc_n;
    assign gt     = sref_q > ramp_q;
    assign lt     = sref_q < ramp_q;
    assign mag_up = (gt && ramp_q >= 0) || (lt && ramp_q <= 0);
    assign t_ms   = mag_up ? acc_q : dec_q;
    assign period = 32'(t_ms) * CYC_MS;
    assign racc_n = racc_q + 32'(FULL_SPEED);
    assign ramp_bypass = acc_q == 16'h0000 && dec_q == 16'h0000;

    // one count every period/FULL_SPEED clocks: constant slope.
    // FULL_SPEED stays below one millisecond of clocks, so the
    // ramp never needs more than one count per clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sref_q <= 16'sh0000;
            ramp_q <= 16'sh0000;
            racc_q <= 32'h00000000;
        end else begin
            sref_q <= sat16(17'(vref_code) - 17'(offset_q));
            if (ramp_bypass || t_ms == 16'h0000) begin
                ramp_q <= sref_q;
                racc_q <= 32'h00000000;
            end else if (!gt && !lt) begin
                racc_q <= 32'h00000000;
            end else if (racc_n >= period) begin
                racc_q <= racc_n - period;
                ramp_q <= gt ? ramp_q + 16'sh0001 : ramp_q - 16'sh0001;
            end else begin
                racc_q <= racc_n;
            end
        end
    end

    // lag filter: every 0.01 ms, y += (x - y) / tau
    logic signed [16:0] fdiff;
    logic [15:0] fmag;
    logic        ftick, div_done;
    logic [31:0] div_quo;
    logic signed [32:0] y_up, y_dn;
    assign fdiff = 17'(ramp_q) - 17'($signed(y_q[31:FRAC]));
    assign fmag  = fdiff[16] ? 16'(-fdiff) : fdiff[15:0];
    assign ftick = ftick_q == 16'(FTICK_CYC - 1);
    assign y_up  = 33'(y_q) + 33'(div_quo);
    assign y_dn  = 33'(y_q) - 33'(div_quo);

    srcf_div u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (ftick && filt_q != 16'h0000),
        .num     ({fmag, 16'h0000}),
        .den     (filt_q),
        .done_q  (div_done),
        .quo_q   (div_quo)
    );

    // the divide takes 33 clocks, well inside one filter step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ftick_q <= 16'h0000;
            neg_q   <= 1'b0;
            y_q     <= 32'sh00000000;
        end else begin
            ftick_q <= ftick ? 16'h0000 : ftick_q + 16'h0001;
            if (ftick) neg_q <= fdiff[16];
            if (filt_q == 16'h0000) y_q <= {ramp_q, 16'h0000};
            else if (div_done)
                y_q <= neg_q ? y_dn[31:0] : y_up[31:0];
        end
    end

    // speed loop reference
    always_ff @(posedge aclk) begin
        if (!aresetn) speed_cmd_q <= 16'sh0000;
        else speed_cmd_q <= y_q[31:FRAC];
    end
endmodule // srcf_top
`default_nettype wire

/* File: srcf_top_note_placeholder.sv */
`default_nettype none
`default_nettype wire

/* File: srcf_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module srcf_chk (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire srcf_pkg::srcf_keys_t keys,
    input wire logic                 servo_on_n,
    input wire srcf_pkg::srcf_disp_t disp_q
);
    import srcf_pkg::*;
    logic [6:0] kh_q [1:5];
    logic [6:0] hist;
    srcf_ui_t   scr;
    // keys two to five edges back; the display lags a key by that much
    assign scr  = disp_q.screen;
    assign hist = kh_q[2] | kh_q[3] | kh_q[4] | kh_q[5];
    always_ff @(posedge aclk) begin
        kh_q[1] <= keys;
        for (int i = 2; i <= 5; i++) begin
            kh_q[i] <= kh_q[i-1];
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // the completion screen holds, then falls back to adjustment entry
    sequence s_done_run;
        (scr == UI_DONE) [*8];
    endsequence
    a_open_cause: assert property (
        scr == UI_ENTRY && $past(scr) == UI_UTIL |-> hist[6] || hist[5])
        else $error("adjustment opened without enter or shift");
    a_show_cause: assert property (
        scr == UI_SHOW && $past(scr) == UI_ENTRY
        |-> hist[5] || hist[3] || hist[2])
        else $error("offset shown without a key");
    a_edit_step: assert property (
        scr == UI_SHOW && $past(scr) == UI_SHOW
        && disp_q.value != $past(disp_q.value) |-> (hist[1] || hist[0])
        && (disp_q.value - $past(disp_q.value) == 16'h0001
        || $past(disp_q.value) - disp_q.value == 16'h0001))
        else $error("offset edit not a single up or down step");
    a_edit_servo: assert property (
        scr == UI_SHOW && $past(scr) == UI_SHOW
        && disp_q.value != $past(disp_q.value) |-> !$past(servo_on_n, 2))
        else $error("offset edited with servo off");
    a_done_blink: assert property (
        scr == UI_DONE |-> disp_q.blink)
        else $error("completion screen not blinking");
    a_done_return: assert property (
        $rose(scr == UI_DONE) |-> s_done_run ##[1:4] scr == UI_ENTRY)
        else $error("completion screen length wrong");
    a_commit_keep: assert property (
        scr == UI_DONE && $past(scr) == UI_SHOW
        |-> disp_q.value == $past(disp_q.value) && hist[4:2] != 3'b000)
        else $error("committed offset differs from edited one");
    a_leave_cause: assert property (
        scr == UI_UTIL && $past(scr) inside {UI_ENTRY, UI_SHOW}
        |-> hist[6] || hist[5])
        else $error("left adjustment without enter or shift");
    a_entry_hold: assert property (
        scr == UI_ENTRY && $past(scr) == UI_ENTRY |-> $stable(disp_q.value))
        else $error("stored offset drifted");
    a_read_answer: assert property (                         // bus timing
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // srcf_chk
bind srcf_top srcf_chk u_chk (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .keys, .servo_on_n, .disp_q
);
`default_nettype wire

/* File: srcf_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host controller plus keypad; every change lands just after a rising edge
module srcf_host (
    input  wire logic              aclk,
    output var srcf_pkg::srcf_keys_t keys,
    output var logic               servo_on_n,
    output var logic signed [15:0] vref_code
);
    import srcf_pkg::*;
    // idle keypad, servo off, zero reference at power-up
    initial begin
        keys       = '0;
        servo_on_n = 1'b1;
        vref_code  = 16'sh0000;
    end
    // the operator adjusts offset by hand, one key at a time, then waits
    task automatic press(input int b, input int n);
        logic [6:0] k;
        k    = '0;
        k[b] = 1'b1;
        keys <= k;
        repeat (n) @(posedge aclk);
        keys <= '0;
        repeat (6) @(posedge aclk);
    endtask
    // servo-on goes low before any offset edit is expected to work
    task automatic host(input logic son_n, input logic signed [15:0] v);
        servo_on_n <= son_n;
        vref_code  <= v;
    endtask
endmodule // srcf_host
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import srcf_pkg::*;
    localparam int K_ENTER = 6, K_SHIFT = 5, K_MODE = 4;
    localparam int K_LEFT = 3, K_RIGHT = 2, K_UP = 1, K_DOWN = 0;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, son_n;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic signed [15:0] vref, cmd;
    srcf_keys_t  keys;
    srcf_disp_t  disp;
    int          err_total = 0, checked = 0, cyc = 0;
    srcf_top #(.LONG_CYC(20), .DONE_CYC(10), .CYC_MS(4)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .keys(keys), .servo_on_n(son_n),
        .vref_code(vref), .speed_cmd_q(cmd), .disp_q(disp)
    );
    srcf_host u_host (.aclk(aclk), .keys(keys), .servo_on_n(son_n),
                      .vref_code(vref));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // both channels offered together, each dropped once its ready is seen
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    task automatic dchk(input srcf_ui_t s, input logic [15:0] v);
        chk({14'h0, disp.screen, disp.value}, {14'h0, s, v});
    endtask
    // settle on the expected command; a bound stops a stuck output
    task automatic wcmd(input logic signed [15:0] e, input int lim);
        for (int n = 0; n < lim && cmd !== e; n++) @(posedge aclk);
        chk({16'h0, cmd}, {16'h0, e});
    endtask
    task automatic mid(input logic signed [15:0] lo, hi);
        chk({31'h0, cmd > lo && cmd < hi}, 32'h1);
    endtask
    task automatic summarize();
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // whole run needs under four thousand cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(A_ACC, 32'h0, RESP_OK);
        rd(A_DEC, 32'h0, RESP_OK);
        rd(A_FILT, {16'h0, FILT_RST}, RESP_OK);
        rd(5'h1c, 32'h0, RESP_ERR);
        wr(A_OFS, 32'h5, 4'hf, RESP_ERR);
        rd(A_OFS, 32'h0, RESP_OK);
        wr(A_ACC, 32'h4e20, 4'hf, RESP_OK);
        rd(A_ACC, {16'h0, RAMP_MAX}, RESP_OK);
        wr(A_DEC, 32'hffff, 4'hf, RESP_OK);
        rd(A_DEC, {16'h0, RAMP_MAX}, RESP_OK);
        wr(A_ACC, 32'h5, 4'h1, RESP_OK);
        rd(A_ACC, {16'h0, RAMP_MAX[15:8], 8'h05}, RESP_OK);
        // keypad is dead until the manual offset utility is selected
        u_host.press(K_ENTER, 1);
        dchk(UI_UTIL, 16'h0);
        wr(A_CTRL, 32'h1, 4'hf, RESP_OK);
        u_host.press(K_ENTER, 1);
        dchk(UI_ENTRY, 16'h0);
        u_host.press(K_RIGHT, 1);
        dchk(UI_SHOW, 16'h0);
        u_host.press(K_UP, 1);
        dchk(UI_SHOW, 16'h0);
        u_host.host(1'b0, 16'sh0);
        repeat (3) u_host.press(K_UP, 1);
        dchk(UI_SHOW, 16'h3);
        u_host.press(K_DOWN, 1);
        dchk(UI_SHOW, 16'h2);
        u_host.press(K_RIGHT, 1);
        dchk(UI_DONE, 16'h2);
        chk({31'h0, disp.blink}, 32'h1);
        rd(A_OFS, 32'h2, RESP_OK);
        repeat (12) @(posedge aclk);
        dchk(UI_ENTRY, 16'h2);
        u_host.press(K_SHIFT, 3);
        dchk(UI_SHOW, 16'h2);
        u_host.press(K_UP, 1);
        u_host.press(K_MODE, 3);
        dchk(UI_DONE, 16'h3);
        repeat (12) @(posedge aclk);
        u_host.press(K_LEFT, 1);
        u_host.press(K_DOWN, 1);
        dchk(UI_SHOW, 16'h2);
        u_host.press(K_ENTER, 1);
        dchk(UI_UTIL, 16'h3);
        u_host.press(K_SHIFT, 25);
        dchk(UI_ENTRY, 16'h3);
        u_host.press(K_SHIFT, 25);
        dchk(UI_UTIL, 16'h3);
        // offset 3 now stored; ramp and filter off means a direct path
        wr(A_ACC, 32'h0, 4'hf, RESP_OK);
        wr(A_DEC, 32'h0, 4'hf, RESP_OK);
        wr(A_FILT, 32'h0, 4'hf, RESP_OK);
        u_host.host(1'b0, 16'sd1000);
        wcmd(16'sd997, 40);
        rd(A_SPD, 32'h3e5, RESP_OK);
        u_host.host(1'b0, 16'sd3);
        wcmd(16'sd0, 40);
        // full-scale time: slope under one count per clock, either way
        wr(A_ACC, {16'h0, RAMP_MAX}, 4'hf, RESP_OK);
        u_host.host(1'b0, 16'sd1000);
        repeat (200) @(posedge aclk);
        mid(16'sd100, 16'sd300);
        wcmd(16'sd997, 3000);
        u_host.host(1'b0, 16'sd3);
        wcmd(16'sd0, 40);
        wr(A_ACC, 32'h0, 4'hf, RESP_OK);
        wr(A_DEC, {16'h0, RAMP_MAX}, 4'hf, RESP_OK);
        u_host.host(1'b0, 16'sd1000);
        wcmd(16'sd997, 40);
        u_host.host(1'b0, 16'sd3);
        repeat (200) @(posedge aclk);
        mid(16'sd697, 16'sd900);
        wcmd(16'sd0, 3000);
        // default lag moves about a fortieth of the gap per 500 clocks
        wr(A_DEC, 32'h0, 4'hf, RESP_OK);
        wr(A_FILT, {16'h0, FILT_RST}, 4'hf, RESP_OK);
        u_host.host(1'b0, 16'sd1003);
        repeat (600) @(posedge aclk);
        mid(16'sd0, 16'sd100);
        wr(A_FILT, 32'h0, 4'hf, RESP_OK);
        wcmd(16'sd1000, 40);
        summarize();
    end
endmodule // tb
`default_nettype wire
